// File: monitor_pkg.sv
// Shared constants for the serial memory monitor.
// Behaviour
// - Beep replies o, k, tick byte, call count, self-test high and low, and starts a tone as the reply begins.
// - Tick byte is the low 8 bits of a counter advancing 28800 times a second.
// - Call count rises by one for every beep or liveness query serviced.
// - Liveness query sends the beep reply but plays no tone.
// - Multi-byte fields travel most significant byte first.
// - Start names the first word, length the word count; addresses ascend.
// - Data read returns two bytes a word, 16-bit checksum, then dollar and bang.
// - Program read returns three bytes a word, 24-bit checksum, then the terminator.
// - Data write takes two bytes a word, stores them, answers bang and 16-bit checksum.
// - Program write takes three bytes a word, stores, answers bang and 24-bit checksum.
// - Execute answers bang, then echoes both entry address bytes.
// - After the echo, user code is called and commands resume on its return.
// - Interrupt mask is cleared to zero before user code is entered.
// - After reset, self-test and codec set-up run, then commands are awaited.
// - The beep tone is 1 kHz.
// - Every memory block moved carries a checksum for comparison by the host.
package monitor_pkg;
	localparam int          CLK_HZ        = 20_000_000;
	localparam int          TICK_HZ       = 28800;
	localparam int          TICK_DIV      = CLK_HZ / TICK_HZ;
	localparam int          BAUD_BPS      = 9600;
	localparam int          BAUD_DIV      = CLK_HZ / BAUD_BPS;
	localparam int          TONE_HZ       = 1000;
	localparam int          TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);
	localparam int          TONE_MS       = 100;
	localparam int          TONE_CYC      = (CLK_HZ / 1000) * TONE_MS;
	localparam int          INT_MASK_W    = 10;
	localparam logic [9:0]  MASK_MON      = 10'h3ff;
	localparam logic [9:0]  MASK_USER     = 10'h000;
	localparam logic [7:0]  CH_DOLLAR     = 8'h24;
	localparam logic [7:0]  CH_BANG       = 8'h21;
	localparam logic [7:0]  CH_LO_O       = 8'h6f;
	localparam logic [7:0]  CH_LO_K       = 8'h6b;
	localparam logic [15:0] CMD_BEEP      = 16'h2424;
	localparam logic [15:0] CMD_ALIVE     = 16'h4f4b;
	localparam logic [15:0] CMD_RD_DATA   = 16'h5544;
	localparam logic [15:0] CMD_RD_PROG   = 16'h5550;
	localparam logic [15:0] CMD_WR_DATA   = 16'h4444;
	localparam logic [15:0] CMD_WR_PROG   = 16'h4450;
	localparam logic [15:0] CMD_GO        = 16'h474f;
	localparam logic [2:0]  HDR_XFER_B    = 3'h4;
	localparam logic [2:0]  HDR_GO_B      = 3'h2;
	localparam logic [1:0]  DATA_WORD_B   = 2'h2;
	localparam logic [1:0]  PROG_WORD_B   = 2'h3;
	typedef enum logic [1:0] {OP_RD, OP_WR, OP_GO} op_t;
endpackage

// File: tone_gen.sv
// Timed square-wave tone generator for the beep reply.
module tone_gen #(
	parameter int HALF_CYC = monitor_pkg::TONE_HALF_CYC,
	parameter int LEN_CYC  = monitor_pkg::TONE_CYC
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic start,
	output logic      tone_out
);
	import monitor_pkg::*;
	logic [31:0] half_ff, nxt_half;
	logic [31:0] left_ff, nxt_left;
	logic        wave_ff, nxt_wave;

	// A new beep while one sounds restarts the full length rather than queueing.
	always_comb begin
		nxt_half = half_ff;
		nxt_left = left_ff;
		nxt_wave = wave_ff;
		if (start) begin
			nxt_left = 32'(LEN_CYC);
			nxt_half = 32'(HALF_CYC - 1);
			nxt_wave = 1'b1;
		end else if (left_ff != 32'h0) begin
			nxt_left = left_ff - 32'h1;
			if (half_ff == 32'h0) begin
				nxt_half = 32'(HALF_CYC - 1);
				nxt_wave = ~wave_ff;
			end else begin
				nxt_half = half_ff - 32'h1;
			end
		end else begin
			nxt_wave = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			half_ff <= 32'h0;
			left_ff <= 32'h0;
			wave_ff <= 1'b0;
		end else begin
			half_ff <= nxt_half;
			left_ff <= nxt_left;
			wave_ff <= nxt_wave;
		end
	end

	assign tone_out = wave_ff;

	a_tone_half: assert property (@(posedge clk) disable iff (reset)
		(left_ff > 32'h1 && half_ff == 32'h0 && !start) |=> (wave_ff != $past(wave_ff)))
		else $error("Tone did not toggle at the half period.");
endmodule

// File: serial_memory_monitor.sv
// Command interpreter for the serial memory monitor.
module serial_memory_monitor #(
	parameter int TONE_HALF = monitor_pkg::TONE_HALF_CYC,
	parameter int TONE_LEN  = monitor_pkg::TONE_CYC
) (
	input  wire logic                            clk,
	input  wire logic                            reset,
	input  wire logic                            rx_valid,
	input  wire logic [7:0]                      rx_data,
	output logic                                 rx_ready,
	output logic                                 tx_valid,
	output logic [7:0]                           tx_data,
	input  wire logic                            tx_ready,
	output logic                                 baud_tick,
	output logic                                 init_start,
	input  wire logic                            init_done,
	input  wire logic [15:0]                     init_result,
	output logic                                 mem_prog,
	output logic [15:0]                          mem_addr,
	output logic                                 mem_re,
	output logic                                 mem_we,
	output logic [23:0]                          mem_wdata,
	input  wire logic [23:0]                     mem_rdata,
	output logic                                 user_call,
	output logic [15:0]                          user_entry,
	input  wire logic                            user_return,
	output logic [monitor_pkg::INT_MASK_W-1:0]   interrupt_mask_register,
	output logic                                 tone_out
);
	import monitor_pkg::*;

	typedef enum logic [3:0] {
		S_INIT, S_INITW, S_SYNC, S_C1, S_C2, S_HDR, S_RDREQ, S_RDWAIT, S_RXW, S_SEND, S_CALL, S_USER
	} state_t;

	state_t      state_ff, nxt_state, ret_ff, nxt_ret;
	op_t         op_ff, nxt_op;
	logic        prog_ff, nxt_prog;
	logic [7:0]  c1_ff, nxt_c1;
	logic [2:0]  hcnt_ff, nxt_hcnt;
	logic [23:0] hdr_ff, nxt_hdr;
	logic [15:0] addr_ff, nxt_addr;
	logic [15:0] len_ff, nxt_len;
	logic [23:0] sum_ff, nxt_sum;
	logic [47:0] buf_ff, nxt_buf;
	logic [2:0]  bcnt_ff, nxt_bcnt;
	logic [1:0]  wcnt_ff, nxt_wcnt;
	logic [23:0] acc_ff, nxt_acc;
	logic        re_ff, nxt_re;
	logic        we_ff, nxt_we;
	logic [23:0] wdata_ff, nxt_wdata;
	logic [15:0] entry_ff, nxt_entry;
	logic [15:0] self_ff, nxt_self;
	logic [7:0]  alive_ff, nxt_alive;
	logic [INT_MASK_W-1:0] mask_ff, nxt_mask;
	logic        tone_go;
	logic        svc;
	logic [31:0] hdr_full;
	logic [23:0] word_in;
	logic [47:0] sum_msg;

	logic [9:0]  tdiv_ff;
	logic [11:0] bdiv_ff;
	logic [7:0]  tick_ff;
	logic        tick_en;

	// Bytes per word; the sum is cut to the checksum width of the memory.
	function automatic logic [1:0] word_bytes(input logic prog);
		return prog ? PROG_WORD_B : DATA_WORD_B;
	endfunction

	function automatic logic [23:0] trim_sum(input logic prog, input logic [23:0] s);
		return prog ? s : {8'h00, s[15:0]};
	endfunction

	// Left-justifies the checksum for sending, high byte first.
	function automatic logic [47:0] sum_bytes(input logic prog, input logic [23:0] s);
		return prog ? {s, 24'h0} : {s[15:0], 32'h0};
	endfunction

	// Free-running tick and bit-rate dividers; the UART engine outside uses baud_tick.
	always_ff @(posedge clk) begin
		if (reset) begin
			tdiv_ff <= 10'h0;
			bdiv_ff <= 12'h0;
			tick_ff <= 8'h0;
		end else begin
			tdiv_ff <= tick_en ? 10'h0 : tdiv_ff + 10'h1;
			bdiv_ff <= baud_tick ? 12'h0 : bdiv_ff + 12'h1;
			if (tick_en) begin
				tick_ff <= tick_ff + 8'h1;
			end
		end
	end
	assign tick_en   = (tdiv_ff == 10'(TICK_DIV - 1));
	assign baud_tick = (bdiv_ff == 12'(BAUD_DIV - 1));

	assign hdr_full = {hdr_ff, rx_data};
	assign word_in  = prog_ff ? {acc_ff[15:0], rx_data} : {8'h00, acc_ff[7:0], rx_data};
	assign sum_msg  = sum_bytes(prog_ff, trim_sum(prog_ff, sum_ff));

	always_comb begin
		nxt_state = state_ff;
		nxt_ret   = ret_ff;
		nxt_op    = op_ff;
		nxt_prog  = prog_ff;
		nxt_c1    = c1_ff;
		nxt_hcnt  = hcnt_ff;
		nxt_hdr   = hdr_ff;
		nxt_addr  = addr_ff;
		nxt_len   = len_ff;
		nxt_sum   = sum_ff;
		nxt_buf   = buf_ff;
		nxt_bcnt  = bcnt_ff;
		nxt_wcnt  = wcnt_ff;
		nxt_acc   = acc_ff;
		nxt_re    = 1'b0;
		nxt_we    = 1'b0;
		nxt_wdata = wdata_ff;
		nxt_entry = entry_ff;
		nxt_self  = self_ff;
		nxt_alive = alive_ff;
		nxt_mask  = mask_ff;
		tone_go   = 1'b0;
		svc       = 1'b0;
		rx_ready  = 1'b0;
		tx_valid  = 1'b0;
		init_start = 1'b0;
		user_call = 1'b0;
		// The address steps once per word, the cycle after the memory strobe.
		if (re_ff || we_ff) begin
			nxt_addr = addr_ff + 16'h1;
		end
		case (state_ff)
			S_INIT: begin
				init_start = 1'b1;
				nxt_state  = S_INITW;
			end
			S_INITW: begin
				if (init_done) begin
					nxt_self  = init_result;
					nxt_state = S_SYNC;
				end
			end
			S_SYNC: begin
				rx_ready = 1'b1;
				if (rx_valid && rx_data == CH_DOLLAR) begin
					nxt_state = S_C1;
				end
			end
			S_C1: begin
				rx_ready = 1'b1;
				if (rx_valid) begin
					nxt_c1    = rx_data;
					nxt_state = S_C2;
				end
			end
			S_C2: begin
				rx_ready = 1'b1;
				if (rx_valid) begin
					nxt_hcnt  = 3'h0;
					nxt_sum   = 24'h0;
					nxt_wcnt  = 2'h0;
					nxt_state = S_HDR;
					case ({c1_ff, rx_data})
						CMD_BEEP, CMD_ALIVE: begin
							svc       = 1'b1;
							nxt_alive = alive_ff + 8'h1;
							tone_go   = ({c1_ff, rx_data} == CMD_BEEP);
							nxt_buf   = {CH_LO_O, CH_LO_K, tick_ff, nxt_alive, self_ff};
							nxt_bcnt  = 3'h6;
							nxt_ret   = S_SYNC;
							nxt_state = S_SEND;
						end
						CMD_RD_DATA, CMD_RD_PROG: begin
							nxt_op   = OP_RD;
							nxt_prog = (rx_data == CMD_RD_PROG[7:0]);
						end
						CMD_WR_DATA, CMD_WR_PROG: begin
							nxt_op   = OP_WR;
							nxt_prog = (rx_data == CMD_WR_PROG[7:0]);
						end
						CMD_GO: begin
							nxt_op = OP_GO;
						end
						default: begin
							nxt_state = S_SYNC;
						end
					endcase
				end
			end
			S_HDR: begin
				rx_ready = 1'b1;
				if (rx_valid) begin
					nxt_hdr  = hdr_full[23:0];
					nxt_hcnt = hcnt_ff + 3'h1;
					if (op_ff == OP_GO && hcnt_ff == HDR_GO_B - 3'h1) begin
						nxt_entry = hdr_full[15:0];
						nxt_buf   = {CH_BANG, hdr_full[15:0], 24'h0};
						nxt_bcnt  = 3'h3;
						nxt_ret   = S_CALL;
						nxt_state = S_SEND;
					end else if (op_ff != OP_GO && hcnt_ff == HDR_XFER_B - 3'h1) begin
						nxt_addr  = hdr_full[31:16];
						nxt_len   = hdr_full[15:0];
						nxt_state = (op_ff == OP_RD) ? S_RDREQ : S_RXW;
					end
				end
			end
			S_RDREQ: begin
				if (len_ff == 16'h0) begin
					// Sum, then the two-character terminator.
					nxt_buf   = sum_bytes(prog_ff, trim_sum(prog_ff, sum_ff));
					nxt_buf   = prog_ff ? {nxt_buf[47:24], CH_DOLLAR, CH_BANG, 8'h00}
					                    : {nxt_buf[47:32], CH_DOLLAR, CH_BANG, 16'h0000};
					nxt_bcnt  = prog_ff ? 3'h5 : 3'h4;
					nxt_ret   = S_SYNC;
					nxt_state = S_SEND;
				end else begin
					nxt_re    = 1'b1;
					nxt_state = S_RDWAIT;
				end
			end
			S_RDWAIT: begin
				if (!re_ff) begin
					nxt_sum   = trim_sum(prog_ff, sum_ff + mem_rdata);
					nxt_len   = len_ff - 16'h1;
					nxt_buf   = prog_ff ? {mem_rdata, 24'h0} : {mem_rdata[15:0], 32'h0};
					nxt_bcnt  = {1'b0, word_bytes(prog_ff)};
					nxt_ret   = S_RDREQ;
					nxt_state = S_SEND;
				end
			end
			S_RXW: begin
				if (len_ff == 16'h0) begin
					nxt_buf   = {CH_BANG, sum_msg[47:8]};
					nxt_bcnt  = prog_ff ? 3'h4 : 3'h3;
					nxt_ret   = S_SYNC;
					nxt_state = S_SEND;
				end else begin
					rx_ready = 1'b1;
					if (rx_valid) begin
						nxt_acc  = {acc_ff[15:0], rx_data};
						nxt_wcnt = wcnt_ff + 2'h1;
						if (wcnt_ff == word_bytes(prog_ff) - 2'h1) begin
							nxt_wcnt  = 2'h0;
							nxt_we    = 1'b1;
							nxt_wdata = word_in;
							nxt_sum   = trim_sum(prog_ff, sum_ff + word_in);
							nxt_len   = len_ff - 16'h1;
						end
					end
				end
			end
			S_SEND: begin
				tx_valid = 1'b1;
				if (tx_ready) begin
					nxt_buf  = {buf_ff[39:0], 8'h00};
					nxt_bcnt = bcnt_ff - 3'h1;
					if (bcnt_ff == 3'h1) begin
						nxt_state = ret_ff;
					end
				end
			end
			S_CALL: begin
				// Masking first lets user code set up before taking any interrupt.
				nxt_mask  = MASK_USER;
				nxt_state = S_USER;
			end
			S_USER: begin
				user_call = 1'b1;
				if (user_return) begin
					nxt_mask  = MASK_MON;
					nxt_state = S_SYNC;
				end
			end
			default: begin
				nxt_state = S_SYNC;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff <= S_INIT;
			ret_ff   <= S_SYNC;
			op_ff    <= OP_RD;
			prog_ff  <= 1'b0;
			c1_ff    <= 8'h00;
			hcnt_ff  <= 3'h0;
			hdr_ff   <= 24'h0;
			addr_ff  <= 16'h0;
			len_ff   <= 16'h0;
			sum_ff   <= 24'h0;
			buf_ff   <= 48'h0;
			bcnt_ff  <= 3'h0;
			wcnt_ff  <= 2'h0;
			acc_ff   <= 24'h0;
			re_ff    <= 1'b0;
			we_ff    <= 1'b0;
			wdata_ff <= 24'h0;
			entry_ff <= 16'h0;
			self_ff  <= 16'h0;
			alive_ff <= 8'h00;
			mask_ff  <= MASK_MON;
		end else begin
			state_ff <= nxt_state;
			ret_ff   <= nxt_ret;
			op_ff    <= nxt_op;
			prog_ff  <= nxt_prog;
			c1_ff    <= nxt_c1;
			hcnt_ff  <= nxt_hcnt;
			hdr_ff   <= nxt_hdr;
			addr_ff  <= nxt_addr;
			len_ff   <= nxt_len;
			sum_ff   <= nxt_sum;
			buf_ff   <= nxt_buf;
			bcnt_ff  <= nxt_bcnt;
			wcnt_ff  <= nxt_wcnt;
			acc_ff   <= nxt_acc;
			re_ff    <= nxt_re;
			we_ff    <= nxt_we;
			wdata_ff <= nxt_wdata;
			entry_ff <= nxt_entry;
			self_ff  <= nxt_self;
			alive_ff <= nxt_alive;
			mask_ff  <= nxt_mask;
		end
	end

	assign tx_data    = buf_ff[47:40];
	assign mem_prog   = prog_ff;
	assign mem_addr   = addr_ff;
	assign mem_re     = re_ff;
	assign mem_we     = we_ff;
	assign mem_wdata  = wdata_ff;
	assign user_entry = entry_ff;
	assign interrupt_mask_register = mask_ff;

	tone_gen #(
		.HALF_CYC (TONE_HALF),
		.LEN_CYC  (TONE_LEN)
	) u_tone (
		.clk      (clk),
		.reset    (reset),
		.start    (tone_go),
		.tone_out (tone_out)
	);

	a_beep_reply: assert property (@(posedge clk) disable iff (reset)
		tone_go |=> (state_ff == S_SEND && buf_ff[47:32] == {CH_LO_O, CH_LO_K} && bcnt_ff == 3'h6))
		else $error("Beep reply does not open with ok.");
	a_tick_step: assert property (@(posedge clk) disable iff (reset)
		tick_en |=> (tick_ff == $past(tick_ff) + 8'h1) && !tick_en)
		else $error("Tick counter did not advance once.");
	a_alive_count: assert property (@(posedge clk) disable iff (reset)
		svc |=> (alive_ff == $past(alive_ff) + 8'h1) && (buf_ff[23:16] == alive_ff))
		else $error("Call count not raised and reported.");
	a_alive_quiet: assert property (@(posedge clk) disable iff (reset)
		(svc && c1_ff == CMD_ALIVE[15:8]) |-> !tone_go)
		else $error("Liveness query started a tone.");
	a_addr_ascend: assert property (@(posedge clk) disable iff (reset)
		(mem_we || mem_re) |=> (mem_addr == $past(mem_addr) + 16'h1))
		else $error("Address did not ascend after a word.");
	a_sum_read: assert property (@(posedge clk) disable iff (reset)
		(state_ff == S_RDWAIT && !re_ff) |=> (sum_ff == trim_sum(prog_ff, $past(sum_ff) + $past(mem_rdata))))
		else $error("Checksum not the truncated word sum.");
	a_go_echo: assert property (@(posedge clk) disable iff (reset)
		(state_ff == S_HDR && nxt_ret == S_CALL && nxt_state == S_SEND)
		|=> (tx_data == CH_BANG && buf_ff[39:24] == user_entry))
		else $error("Execute reply not bang and address echo.");
	a_mask_first: assert property (@(posedge clk) disable iff (reset)
		user_call |-> (interrupt_mask_register == MASK_USER))
		else $error("User code entered with interrupts unmasked.");
	a_init_wait: assert property (@(posedge clk) disable iff (reset)
		(state_ff == S_INITW && !init_done) |=> (state_ff == S_INITW && !rx_ready))
		else $error("Commands taken before self-test finished.");
	a_wr_store: assert property (@(posedge clk) disable iff (reset)
		(state_ff == S_RXW && rx_valid && len_ff != 16'h0 && wcnt_ff == word_bytes(prog_ff) - 2'h1)
		|=> mem_we ##1 !mem_we)
		else $error("Completed word was not stored once.");
endmodule

// File: host_link_model.sv
// Host end of the byte link: sends queued command bytes and collects reply bytes.
module host_link_model (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       slow,
	input  wire logic       rx_ready,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            tx_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] send_q[$];
	logic [7:0] got_q[$];
	logic [1:0] ph_ff;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
		ph_ff = 2'h0;
	end
	// A stalling host is ready for a reply byte one cycle in four, so the device must hold its offer.
	always @(posedge clk) begin
		ph_ff <= ph_ff + 2'h1;
		tx_ready <= !reset && (!slow || ph_ff == 2'h0);
		if (tx_valid && tx_ready) begin
			got_q.push_back(tx_data);
		end
		if (rx_valid && rx_ready) begin
			void'(send_q.pop_front());
		end
		if (!reset && send_q.size() != 0) begin
			rx_valid <= 1'b1;
			rx_data <= send_q[0];
		end else begin
			// An idle line must not keep showing the last byte.
			rx_valid <= 1'b0;
			rx_data <= ~rx_data;
		end
	end
endmodule

// File: serial_memory_monitor_tb_top.sv
// Self-checking bench for the serial memory monitor.
module serial_memory_monitor_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import monitor_pkg::*;
	localparam int HALF = 4;
	localparam int LEN = 40;
	logic clk, reset, slow, rx_valid, rx_ready, tx_valid, tx_ready, baud_tick, init_start, init_done;
	logic mem_prog, mem_re, mem_we, user_call, user_return, tone_out, prog;
	logic [7:0] rx_data, tx_data, t1, t2, alive_cnt;
	logic [15:0] init_result, mem_addr, user_entry, self_result, start, entry, code;
	logic [23:0] mem_wdata, mem_rdata;
	logic [INT_MASK_W-1:0] interrupt_mask_register;
	logic [31:0] seed;
	logic [23:0] prog_img[int];
	logic [15:0] data_img[int];
	logic [23:0] w[0:8];
	logic [7:0] cq[$];
	logic [7:0] eq[$];
	int n_errors, checks, cyc, skip, rises, last_rise, per, t0, n, nb, bper, blast;

	serial_memory_monitor #(.TONE_HALF(HALF), .TONE_LEN(LEN)) u_serial_memory_monitor (
		.clk, .reset, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready, .baud_tick,
		.init_start, .init_done, .init_result, .mem_prog, .mem_addr, .mem_re, .mem_we, .mem_wdata,
		.mem_rdata, .user_call, .user_entry, .user_return, .interrupt_mask_register, .tone_out);
	host_link_model u_host_link_model (
		.clk, .reset, .slow, .rx_ready, .tx_valid, .tx_data, .rx_valid, .rx_data, .tx_ready);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Memory answers one cycle after the read strobe and shows garbage otherwise.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (mem_we && mem_prog) prog_img[mem_addr] = mem_wdata;
		if (mem_we && !mem_prog) data_img[mem_addr] = mem_wdata[15:0];
		mem_rdata <= !mem_re ? ~mem_rdata : mem_prog ? prog_img[mem_addr] : {8'h00, data_img[mem_addr]};
		// The bit-rate enable spacing is measured so the UART engine sees the right rate.
		if (baud_tick) begin
			bper <= cyc - blast;
			blast <= cyc;
		end
	end
	always @(posedge tone_out) begin
		per = cyc - last_rise;
		last_rise = cyc;
		rises++;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [23:0] cks(input int cnt, input logic p);
		logic [23:0] s;
		s = 24'h000000;
		for (int i = 0; i < cnt; i++) s = s + w[i];
		return p ? s : {8'h00, s[15:0]};
	endfunction
	task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d, n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic wait_for(input int cnt);
		for (int k = 0; k < 20000 && u_host_link_model.got_q.size() < cnt; k++) @(posedge clk);
		if (u_host_link_model.got_q.size() < cnt) begin
			cmp(24'(u_host_link_model.got_q.size()), 24'(cnt));
			complete_run();
		end
	endtask
	task automatic put(input logic [23:0] v, input int nbytes, input logic to_eq);
		for (int b = nbytes - 1; b >= 0; b--) begin
			if (to_eq) eq.push_back(v[8*b +: 8]);
			else cq.push_back(v[8*b +: 8]);
		end
	endtask
	// Queries never stall, so the tick sample point stays at a fixed offset from the command.
	task automatic xact();
		u_host_link_model.got_q.delete();
		@(posedge clk);
		slow <= seed[5] && skip < 0;
		foreach (cq[i]) u_host_link_model.send_q.push_back(cq[i]);
		wait_for(eq.size());
		repeat (6) @(posedge clk);
		cmp(24'(u_host_link_model.got_q.size()), 24'(eq.size()));
		foreach (eq[i]) if (i != skip) cmp({16'h0, u_host_link_model.got_q[i]}, {16'h0, eq[i]});
		cq.delete();
		eq.delete();
		skip = -1;
		seed = lfsr(seed);
	endtask
	task automatic query(input logic [15:0] c, output logic [7:0] tick);
		alive_cnt++;
		cq = {8'h41, CH_DOLLAR, 8'h5a, 8'h51, CH_DOLLAR, c[15:8], c[7:0]};
		eq = {CH_LO_O, CH_LO_K, 8'h00, alive_cnt, self_result[15:8], self_result[7:0]};
		skip = 2;
		rises = 0;
		xact();
		tick = u_host_link_model.got_q[2];
		cmp(24'(rises != 0), 24'(c == CMD_BEEP));
	endtask

	initial begin
		reset = 1'b1;
		slow = 1'b0;
		init_done = 1'b0;
		init_result = 16'h0000;
		user_return = 1'b0;
		mem_rdata = 24'h000000;
		seed = 32'h427a6d99;
		skip = -1;
		alive_cnt = 8'h00;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		#1 cmp(24'(init_start), 24'h1);
		cmp(24'(rx_ready), 24'h0);
		@(posedge clk);
		#1 cmp(24'(init_start), 24'h0);
		cmp(24'(rx_ready), 24'h0);
		repeat (3) @(posedge clk);
		self_result = seed[31:16];
		init_done <= 1'b1;
		init_result <= seed[31:16];
		@(posedge clk);
		init_done <= 1'b0;
		init_result <= ~seed[31:16];
		seed = lfsr(seed);
		query(CMD_BEEP, t1);
		repeat (60) @(posedge clk);
		cmp(24'(per), 24'(2 * HALF));
		t0 = cyc;
		query(CMD_ALIVE, t1);
		while (cyc < t0 + 10 * TICK_DIV) @(posedge clk);
		query(CMD_ALIVE, t2);
		cmp({16'h0, 8'(t2 - t1)}, 24'h00000a);
		for (int k = 0; k < 6; k++) begin
			prog = k[0];
			nb = prog ? 3 : 2;
			n = (k < 2) ? 0 : int'(seed[2:0]) + 1;
			start = (k >= 4) ? (prog ? 16'h3800 : 16'h3e00) - 16'(n) : {5'h00, seed[26:16]};
			cq.push_back(CH_DOLLAR);
			put(24'(prog ? CMD_WR_PROG : CMD_WR_DATA), 2, 1'b0);
			put(24'(start), 2, 1'b0);
			put(24'(n), 2, 1'b0);
			for (int i = 0; i < n; i++) begin
				seed = lfsr(seed);
				w[i] = prog ? seed[23:0] : {8'h00, seed[15:0]};
				put(w[i], nb, 1'b0);
			end
			eq.push_back(CH_BANG);
			put(cks(n, prog), nb, 1'b1);
			xact();
			// Fresh contents are placed behind the design so the read cannot echo the write.
			for (int i = 0; i < n; i++) begin
				cmp(prog ? prog_img[start + i] : data_img[start + i], w[i]);
				seed = lfsr(seed);
				w[i] = prog ? seed[23:0] : {8'h00, seed[15:0]};
				if (prog) prog_img[start + i] = w[i];
				else data_img[start + i] = w[i][15:0];
				put(w[i], nb, 1'b1);
			end
			cq.push_back(CH_DOLLAR);
			put(24'(prog ? CMD_RD_PROG : CMD_RD_DATA), 2, 1'b0);
			put(24'(start), 2, 1'b0);
			put(24'(n), 2, 1'b0);
			put(cks(n, prog), nb, 1'b1);
			put({8'h00, CH_DOLLAR, CH_BANG}, 2, 1'b1);
			xact();
		end
		entry = seed[15:0];
		cq = {CH_DOLLAR, CMD_GO[15:8], CMD_GO[7:0], entry[15:8], entry[7:0]};
		eq = {CH_BANG, entry[15:8], entry[7:0]};
		xact();
		for (int k = 0; k < 50 && user_call !== 1'b1; k++) @(posedge clk);
		cmp(24'(interrupt_mask_register), 24'h000000);
		cmp(24'(user_entry), 24'(entry));
		u_host_link_model.send_q.push_back(8'h41);
		repeat (20) @(posedge clk);
		cmp(24'(user_call), 24'h1);
		cmp(24'(u_host_link_model.send_q.size()), 24'h1);
		user_return <= 1'b1;
		@(posedge clk);
		user_return <= 1'b0;
		repeat (3) @(posedge clk);
		cmp(24'(user_call), 24'h0);
		cmp(24'(interrupt_mask_register), 24'(MASK_MON));
		query(CMD_ALIVE, t1);
		cmp(24'(bper), 24'(BAUD_DIV));
		complete_run();
	end
endmodule
